/* hw/utx_usart_tx.sv */
`default_nettype none
`include "utx_map.svh"

// Functional notes
// - Adjustment code decodes to factors 1,2,4,8,16,32,12,20.
// - Division code decodes to factors 372 up to 2048.
// - Smart-card clock is selected source divided by baud divisor, optionally driven out.
// - Smart-card bit time is that clock divided by integer ratio up to 2047.
// - Ratio field resets to 0x174.
// - Receiver and transmitter start disabled; enabled independently by control bits.
// - Soft resets stop a direction at once, clear flags, keep configuration.
// - Receiver disable waits until the current character is received.
// - Transmitter disable finishes current and held character first.
// - Frame is start, data, optional parity, stop bits; changes on clock fall.
// - Data length from char_length, or nine when nine_bit_mode is set.
// - Parity is even, odd, space, mark or none.
// - high_bit_first selects most significant bit first, else least first.
// - Stop bits follow stop_count; one and a half only in asynchronous mode.
// - Held character moves to shifter, holding_free rises; tx_all_done when all sent.
// - Flags read low while disabled; writes while holding is full are dropped.
// - biphase_enable encodes characters with a transition mid bit.
// - Optional preamble of 1 to 15 bit times in one of four patterns.
// - Default polarity sends zero as low-to-high, one as high-to-low.
// - Delimiter is an encoded zero, or a three bit-time sync pattern.
// - Command sync is high one and a half bits then low; next_is_command selects.
// - per_char_delimiter takes the sync type from each written character.
module utx_usart_tx
   import utx_pkg::*;
#(
   parameter int DIV_W = 16,
   parameter int ETU_W = 11,
   parameter int PRESCALE = `UTX_PRESCALE
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_b,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Receiver control.
   input wire logic rx_busy,
   output logic rx_on,
   output logic rx_reset,
   // Serial line.
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   output logic txd
);

   // -------------------------------------------------------------------------
   // Parameter check and decode functions.
   // -------------------------------------------------------------------------
   if (DIV_W < 2 || DIV_W > 16 || ETU_W < 11 || ETU_W > 16 || PRESCALE < 2) begin : g_check
      $error("utx_usart_tx parameters out of range.");
   end

   function automatic logic [5:0] di_of(input logic [3:0] code);
      case (code)
         4'h1: di_of = 6'h01;
         4'h2: di_of = 6'h02;
         4'h3: di_of = 6'h04;
         4'h4: di_of = 6'h08;
         4'h5: di_of = 6'h10;
         4'h6: di_of = 6'h20;
         4'h8: di_of = 6'h0C;
         4'h9: di_of = 6'h14;
         default: di_of = 6'h00;
      endcase
   endfunction

   function automatic logic [11:0] fi_of(input logic [3:0] code);
      case (code)
         4'h0, 4'h1: fi_of = 12'h174;
         4'h2: fi_of = 12'h22E;
         4'h3: fi_of = 12'h2E8;
         4'h4: fi_of = 12'h45C;
         4'h5: fi_of = 12'h5D0;
         4'h6: fi_of = 12'h744;
         4'h9: fi_of = 12'h200;
         4'hA: fi_of = 12'h300;
         4'hB: fi_of = 12'h400;
         4'hC: fi_of = 12'h600;
         4'hD: fi_of = 12'h800;
         default: fi_of = 12'h000;
      endcase
   endfunction

   // -------------------------------------------------------------------------
   // State.
   // -------------------------------------------------------------------------
   utx_mode_type mode_reg;
   utx_biphase_type bip_reg;
   logic [DIV_W-1:0] baud_reg;
   logic [DIV_W-1:0] div_reg;
   logic [ETU_W-1:0] etu_reg;
   logic [ETU_W-1:0] bit_reg;
   logic [3:0] fi_code_reg, di_code_reg;
   logic tx_on_reg, tx_stop_reg, rx_on_reg, rx_stop_reg, rx_reset_reg, hold_full_reg;
   logic txd_reg, sck_reg, sck_oe_reg, ext_lvl_reg, ext_prev_reg, load;
   logic [9:0] hold_reg, shift_reg;
   utx_state_type state_reg, state_next;
   logic [5:0] hcnt_reg, hcnt_next;
   logic [31:0] rdata_reg;
   logic [7:0] pre_reg;
   logic [2:0] ext_sync_reg;

   // -------------------------------------------------------------------------
   // Register port decode.
   // -------------------------------------------------------------------------
   wire wr_cr = reg_wr && reg_addr == `UTX_OFS_CONTROL;
   wire wr_hold = reg_wr && reg_addr == `UTX_OFS_HOLD;
   wire cmd_rxrst = wr_cr && reg_wdata[`UTX_CR_RX_SOFT_RESET];
   wire cmd_txrst = wr_cr && reg_wdata[`UTX_CR_TX_SOFT_RESET];
   wire cmd_rx_enable = wr_cr && reg_wdata[`UTX_CR_RX_ENABLE];
   wire cmd_rx_disable = wr_cr && reg_wdata[`UTX_CR_RX_DISABLE];
   wire cmd_tx_enable = wr_cr && reg_wdata[`UTX_CR_TX_ENABLE];
   wire cmd_tx_disable = wr_cr && reg_wdata[`UTX_CR_TX_DISABLE];
   wire holding_free = tx_on_reg && !hold_full_reg;
   wire tx_all_done = holding_free && state_reg == UTX_IDLE;
   wire hold_take = wr_hold && holding_free;
   wire [5:0] di_val = di_of(di_code_reg);
   wire [11:0] fi_val = fi_of(fi_code_reg);
   wire [31:0] status_val = {28'h000_0000, rx_on_reg, tx_on_reg, tx_all_done, holding_free};
   wire [31:0] rd_val =
      reg_addr == `UTX_OFS_MODE ? {8'h00, mode_reg} :
      reg_addr == `UTX_OFS_STATUS ? status_val :
      reg_addr == `UTX_OFS_BAUD ? 32'(baud_reg) :
      reg_addr == `UTX_OFS_ETU ? {8'h00, di_code_reg, fi_code_reg, 16'(etu_reg)} :
      reg_addr == `UTX_OFS_FACTOR ? {10'h000, di_val, 4'h0, fi_val} :
      reg_addr == `UTX_OFS_BIPHASE ? {19'h0_0000, bip_reg} : 32'h0000_0000;

   // -------------------------------------------------------------------------
   // Clock source and dividers.
   // -------------------------------------------------------------------------
   wire pre_tick = pre_reg == 8'(PRESCALE - 1);
   wire ext_tick = ext_lvl_reg && !ext_prev_reg;
   wire ext_lvl_next = ext_sync_reg[1] == ext_sync_reg[2] ? ext_sync_reg[2] : ext_lvl_reg;
   wire src_tick = mode_reg.divider_source == 2'h0 ? 1'b1 :
                   mode_reg.divider_source == 2'h3 ? ext_tick : pre_tick;
   wire [DIV_W-1:0] baud_m1 = baud_reg - DIV_W'(1);
   wire [DIV_W-1:0] baud_half_m1 = (baud_reg >> 1) - DIV_W'(1);
   wire baud_live = baud_reg != '0;
   wire div_wrap = div_reg == baud_m1;
   wire div_end = src_tick && baud_live && (baud_reg == DIV_W'(1) || div_wrap);
   wire div_mid = src_tick && baud_reg > DIV_W'(1) && div_reg == baud_half_m1;
   wire [DIV_W-1:0] div_next = (!src_tick || !baud_live) ? div_reg :
                               div_wrap ? '0 : div_reg + DIV_W'(1);
   wire [ETU_W-1:0] period = mode_reg.iso_mode ? etu_reg :
                             mode_reg.over8 ? ETU_W'(`UTX_OVERSAMPLE_LOW) :
                             ETU_W'(`UTX_OVERSAMPLE_HIGH);
   wire [ETU_W-1:0] period_m1 = period - ETU_W'(1);
   wire [ETU_W-1:0] period_half_m1 = (period >> 1) - ETU_W'(1);
   wire bit_end = div_end && period != '0 && bit_reg == period_m1;
   wire bit_mid = div_end && period > ETU_W'(1) && bit_reg == period_half_m1;
   wire [ETU_W-1:0] bit_next = !div_end ? bit_reg :
                               bit_reg >= period_m1 ? '0 : bit_reg + ETU_W'(1);
   wire clocked = mode_reg.sync_mode && !mode_reg.iso_mode;
   wire hend = clocked ? div_end : bit_end;
   wire htick = clocked ? (div_mid || div_end) : (bit_mid || bit_end);
   wire sck_next = div_end ? 1'b0 : div_mid ? 1'b1 : sck_reg;

   // -------------------------------------------------------------------------
   // Character format.
   // -------------------------------------------------------------------------
   wire [3:0] nbits = mode_reg.nine_bit_mode ? 4'h9 : 4'h5 + 4'(mode_reg.char_length);
   wire [8:0] data_mask = 9'((10'h001 << nbits) - 10'h001);
   wire [8:0] data_bits = shift_reg[8:0] & data_mask;
   wire par_en = mode_reg.check_bit_type < 3'h4;
   wire par_bit = mode_reg.check_bit_type == 3'h0 ? ^data_bits :
                  mode_reg.check_bit_type == 3'h1 ? ~^data_bits :
                  mode_reg.check_bit_type == 3'h3;
   wire [5:0] stop_len = mode_reg.stop_count == 2'h2 ? 6'h04 :
                         (mode_reg.stop_count == 2'h1 && !clocked) ? 6'h03 : 6'h02;
   wire biphase = mode_reg.biphase_enable;
   wire [3:0] plen = bip_reg.preamble_length;
   wire single = mode_reg.single_cell_delimiter;
   wire [5:0] elem_len = state_reg == UTX_PRE ? {1'b0, plen, 1'b0} :
                         state_reg == UTX_SYNC ? `UTX_SYNC_HALVES :
                         state_reg == UTX_DATA ? {1'b0, nbits, 1'b0} :
                         state_reg == UTX_STOP ? stop_len : 6'h02;
   wire last_half = hcnt_reg == elem_len - 6'h01;
   wire load_ok = hold_full_reg && tx_on_reg;
   utx_state_type first_state;
   assign first_state = !biphase ? UTX_START :
                        plen != 4'h0 ? UTX_PRE :
                        single ? UTX_START : UTX_SYNC;
   wire delim_sel = mode_reg.per_char_delimiter ? hold_reg[9] : mode_reg.next_is_command;
   wire [9:0] shift_next = load ? {delim_sel, hold_reg[8:0]} : shift_reg;

   // -------------------------------------------------------------------------
   // Sequencer, line level and enables.
   // -------------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      hcnt_next = hcnt_reg;
      load = 1'b0;
      if (htick) begin
         if (state_reg == UTX_IDLE) begin
            if (load_ok && hend) begin
               load = 1'b1;
               state_next = first_state;
               hcnt_next = 6'h00;
            end
         end else if (last_half) begin
            hcnt_next = 6'h00;
            case (state_reg)
               UTX_PRE: state_next = single ? UTX_START : UTX_SYNC;
               UTX_SYNC, UTX_START: state_next = UTX_DATA;
               UTX_DATA: state_next = par_en ? UTX_PAR : UTX_STOP;
               UTX_PAR: state_next = UTX_STOP;
               default: begin
                  load = load_ok;
                  state_next = load_ok ? first_state : UTX_IDLE;
               end
            endcase
         end else begin
            hcnt_next = hcnt_reg + 6'h01;
         end
      end
   end

   wire [4:0] idx = hcnt_next[5:1];
   wire [3:0] dpos = mode_reg.high_bit_first ? nbits - 4'h1 - idx[3:0] : idx[3:0];
   wire data_bit = shift_reg[dpos];
   wire [1:0] pat = bip_reg.preamble_pattern;
   wire pre_bit = pat == 2'h0 ? 1'b1 : pat == 2'h1 ? 1'b0 :
                  pat == 2'h2 ? ~idx[0] : idx[0];
   wire sync_lvl = hcnt_next < 6'h03 ? shift_next[9] : ~shift_next[9];
   wire raw_bit = state_next == UTX_PRE ? pre_bit :
                  state_next == UTX_SYNC ? sync_lvl :
                  state_next == UTX_START ? 1'b0 :
                  state_next == UTX_DATA ? data_bit :
                  state_next == UTX_PAR ? par_bit : 1'b1;
   wire encode = biphase && (state_next == UTX_PRE || state_next == UTX_START ||
                             state_next == UTX_DATA || state_next == UTX_PAR);
   wire txd_next = encode ? raw_bit ^ hcnt_next[0] ^ bip_reg.encode_polarity : raw_bit;

   wire tx_drained = state_reg == UTX_IDLE && !hold_full_reg && !cmd_txrst;
   wire tx_on_next = cmd_tx_disable ? tx_on_reg :
                     cmd_tx_enable ? 1'b1 :
                     (tx_stop_reg && tx_drained) ? 1'b0 : tx_on_reg;
   wire tx_stop_next = cmd_tx_disable ? 1'b1 :
                       (cmd_tx_enable || cmd_txrst || tx_drained) ? 1'b0 : tx_stop_reg;
   wire rx_on_next = cmd_rx_disable ? rx_on_reg :
                     cmd_rx_enable ? 1'b1 :
                     (rx_stop_reg && !rx_busy) ? 1'b0 : rx_on_reg;
   wire rx_stop_next = cmd_rx_disable ? 1'b1 :
                       (cmd_rx_enable || cmd_rxrst || !rx_busy) ? 1'b0 : rx_stop_reg;
   wire hold_full_next = cmd_txrst ? 1'b0 : hold_take ? 1'b1 : load ? 1'b0 : hold_full_reg;

   // -------------------------------------------------------------------------
   // Configuration, control and holding registers.
   // -------------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_reg <= '0;
         bip_reg <= '0;
         baud_reg <= '0;
         etu_reg <= ETU_W'(`UTX_ETU_RESET);
         fi_code_reg <= `UTX_FI_CODE_RESET;
         di_code_reg <= `UTX_DI_CODE_RESET;
      end else begin
         if (reg_wr && reg_addr == `UTX_OFS_MODE) begin
            mode_reg <= reg_wdata[23:0];
         end
         if (reg_wr && reg_addr == `UTX_OFS_BIPHASE) begin
            bip_reg <= reg_wdata[12:0];
         end
         if (reg_wr && reg_addr == `UTX_OFS_BAUD) begin
            baud_reg <= reg_wdata[DIV_W-1:0];
         end
         if (reg_wr && reg_addr == `UTX_OFS_ETU) begin
            etu_reg <= ETU_W'(reg_wdata[10:0]);
            fi_code_reg <= reg_wdata[`UTX_ETU_FI_LSB +: 4];
            di_code_reg <= reg_wdata[`UTX_ETU_DI_LSB +: 4];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_on_reg <= 1'b0;
         tx_stop_reg <= 1'b0;
         rx_on_reg <= 1'b0;
         rx_stop_reg <= 1'b0;
         rx_reset_reg <= 1'b0;
         hold_reg <= '0;
         hold_full_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         tx_on_reg <= tx_on_next;
         tx_stop_reg <= tx_stop_next;
         rx_on_reg <= rx_on_next;
         rx_stop_reg <= rx_stop_next;
         rx_reset_reg <= cmd_rxrst;
         hold_full_reg <= hold_full_next;
         if (hold_take) begin
            hold_reg <= {reg_wdata[`UTX_HOLD_DELIM_BIT], reg_wdata[8:0]};
         end
         rdata_reg <= reg_rd ? rd_val : 32'h0000_0000;
      end
   end

   // -------------------------------------------------------------------------
   // Clock generation and transmit sequencer registers.
   // -------------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_reg <= 8'h00;
         ext_sync_reg <= 3'h0;
         ext_lvl_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
         div_reg <= '0;
         bit_reg <= '0;
         sck_reg <= 1'b0;
         sck_oe_reg <= 1'b0;
      end else begin
         pre_reg <= pre_tick ? 8'h00 : pre_reg + 8'h01;
         ext_sync_reg <= {ext_sync_reg[1:0], sck_in};
         ext_lvl_reg <= ext_lvl_next;
         ext_prev_reg <= ext_lvl_reg;
         div_reg <= div_next;
         bit_reg <= bit_next;
         sck_reg <= sck_next;
         sck_oe_reg <= mode_reg.clock_drive_out;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= UTX_IDLE;
         hcnt_reg <= 6'h00;
         shift_reg <= '0;
         txd_reg <= 1'b1;
      end else if (cmd_txrst) begin
         state_reg <= UTX_IDLE;
         hcnt_reg <= 6'h00;
         txd_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         hcnt_reg <= hcnt_next;
         shift_reg <= shift_next;
         if (htick) begin
            txd_reg <= txd_next;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Outputs.
   // -------------------------------------------------------------------------
   assign reg_rdata = rdata_reg;
   assign rx_on = rx_on_reg;
   assign rx_reset = rx_reset_reg;
   assign sck_out = sck_reg;
   assign sck_oe = sck_oe_reg;
   assign txd = txd_reg;

endmodule // utx_usart_tx

`default_nettype wire

/* hw/utx_map.svh */
`ifndef UTX_MAP_SVH
`define UTX_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses).
// ----------------------------------------------------------------------------
`define UTX_OFS_CONTROL 8'h00
`define UTX_OFS_MODE 8'h04
`define UTX_OFS_STATUS 8'h14
`define UTX_OFS_HOLD 8'h1C
`define UTX_OFS_BAUD 8'h20
`define UTX_OFS_ETU 8'h40
`define UTX_OFS_FACTOR 8'h44
`define UTX_OFS_BIPHASE 8'h50

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define UTX_CR_RX_SOFT_RESET 2
`define UTX_CR_TX_SOFT_RESET 3
`define UTX_CR_RX_ENABLE 4
`define UTX_CR_RX_DISABLE 5
`define UTX_CR_TX_ENABLE 6
`define UTX_CR_TX_DISABLE 7
`define UTX_SR_HOLDING_FREE 0
`define UTX_SR_TX_ALL_DONE 1
`define UTX_SR_TX_ON 2
`define UTX_SR_RX_ON 3
`define UTX_HOLD_DELIM_BIT 12
`define UTX_ETU_FI_LSB 16
`define UTX_ETU_DI_LSB 20

// ----------------------------------------------------------------------------
// Reset values and counts.
// ----------------------------------------------------------------------------
`define UTX_ETU_RESET 11'h174
`define UTX_FI_CODE_RESET 4'h0
`define UTX_DI_CODE_RESET 4'h1
`define UTX_PRESCALE 8
`define UTX_OVERSAMPLE_HIGH 16
`define UTX_OVERSAMPLE_LOW 8
`define UTX_SYNC_HALVES 6'h06

`endif

/* hw/utx_pkg.sv */
`default_nettype none

package utx_pkg;

   // Transmit sequencer states, Gray coded in declaration order.
   typedef enum logic [2:0] {
      UTX_IDLE = 3'h0,
      UTX_PRE = 3'h1,
      UTX_SYNC = 3'h3,
      UTX_START = 3'h2,
      UTX_DATA = 3'h6,
      UTX_PAR = 3'h7,
      UTX_STOP = 3'h5
   } utx_state_type;

   // Mode register layout.
   typedef struct packed {
      logic biphase_enable;
      logic per_char_delimiter;
      logic single_cell_delimiter;
      logic next_is_command;
      logic over8;
      logic clock_drive_out;
      logic nine_bit_mode;
      logic high_bit_first;
      logic [1:0] stop_count;
      logic [2:0] check_bit_type;
      logic sync_mode;
      logic [1:0] char_length;
      logic [1:0] divider_source;
      logic [4:0] spare;
      logic iso_mode;
   } utx_mode_type;

   // Biphase configuration register layout.
   typedef struct packed {
      logic encode_polarity;
      logic [1:0] spare_hi;
      logic [1:0] preamble_pattern;
      logic [3:0] spare_lo;
      logic [3:0] preamble_length;
   } utx_biphase_type;

endpackage

`default_nettype wire

/* test/utx_tx_monitor.sv */
`default_nettype none
`include "utx_map.svh"
module utx_tx_monitor (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_b,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Receiver control and serial line.
   input wire logic rx_busy,
   input wire logic rx_on,
   input wire logic rx_reset,
   input wire logic sck_in,
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic txd
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------------------------
   // Decoded writes and a flag that the ratio register was written.
   // ---------------------------------------------------------------
   logic etu_written_reg;
   wire logic ctl_wr = reg_wr && (reg_addr == `UTX_OFS_CONTROL);
   wire logic rx_en_wr = ctl_wr && reg_wdata[4] && !reg_wdata[5];
   wire logic rx_rst_wr = ctl_wr && reg_wdata[2];
   wire logic oe_wr = reg_wr && (reg_addr == `UTX_OFS_MODE) && reg_wdata[18];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         etu_written_reg <= 1'b0;
      end else if (reg_wr && (reg_addr == `UTX_OFS_ETU)) begin
         etu_written_reg <= 1'b1;
      end
   end
   a_rx_on_cause: assert property ($rose(rx_on) |-> $past(rx_en_wr) || $past(rx_en_wr, 2))
      else $error("rx_on rose without an enable write");
   a_rx_off_idle: assert property ($fell(rx_on) |-> !$past(rx_busy))
      else $error("rx_on fell while a character was arriving");
   a_rx_reset_pulse: assert property (rx_rst_wr |=> rx_reset)
      else $error("receiver reset not pulsed");
   a_rx_reset_cause: assert property (rx_reset |-> $past(rx_rst_wr))
      else $error("receiver reset without a write");
   a_tx_reset_idle: assert property (ctl_wr && reg_wdata[3] |-> ##[1:2] txd)
      else $error("txd not idle after transmitter reset");
   a_drive_out_cause: assert property ($rose(sck_oe) |-> $past(oe_wr) || $past(oe_wr, 2))
      else $error("sck_oe rose without a mode write");
   a_ratio_reset_val: assert property (reg_rd && reg_addr == `UTX_OFS_ETU && !etu_written_reg
      |=> reg_rdata[10:0] == 11'h174) else $error("ratio reset value wrong");
   a_flags_need_tx: assert property (reg_rd && reg_addr == `UTX_OFS_STATUS
      |=> reg_rdata[2] || reg_rdata[1:0] == 2'b00) else $error("flags high while disabled");
   a_factor_width: assert property (reg_rd && reg_addr == `UTX_OFS_FACTOR
      |=> reg_rdata[31:22] == 10'h000 && reg_rdata[15:12] == 4'h0)
      else $error("factor read has stray bits");
   c_rx_on: cover property ($rose(rx_on));
   c_tx_start: cover property ($fell(txd));
   c_rx_reset: cover property (rx_reset);
   c_sck_rise: cover property ($rose(sck_out));
endmodule // utx_tx_monitor
bind utx_usart_tx utx_tx_monitor u_mon (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .rx_busy(rx_busy), .rx_on(rx_on), .rx_reset(rx_reset), .sck_in(sck_in),
   .sck_out(sck_out), .sck_oe(sck_oe), .txd(txd));
`default_nettype wire

/* test/utx_line_rx.sv */
`default_nettype none
module utx_line_rx #(
   parameter int BIT = 8
) (
   // Clock and line.
   input wire logic sys_clk,
   input wire logic txd,
   // Received characters.
   output logic [7:0] rx_char,
   output var int rx_count,
   output var int frame_err
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------------------------
   // Remote receiver: eight data bits, least significant first.
   // ---------------------------------------------------------------
   logic [7:0] shift;
   initial begin
      rx_char = 8'h00;
      rx_count = 0;
      frame_err = 0;
      forever begin
         @(negedge txd);
         repeat (BIT / 2) @(posedge sys_clk);
         if (txd !== 1'b0) frame_err++;
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge sys_clk);
            shift[i] = txd;
         end
         repeat (BIT) @(posedge sys_clk);
         if (txd !== 1'b1) frame_err++;
         rx_char = shift;
         rx_count++;
      end
   end
endmodule // utx_line_rx
`default_nettype wire

/* test/utx_usart_tx_tb.sv */
`default_nettype none
`include "utx_map.svh"
module utx_usart_tx_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic rx_busy = 1'b0;
   logic [31:0] reg_rdata, d;
   logic rx_on, rx_reset, sck_out, sck_oe, txd;
   logic [7:0] rx_char;
   logic [7:0] got[$];
   int rx_count, frame_err;
   int errors = 0;
   int tests_run = 0;
   localparam logic [3:0] FI_CODE [12] = '{0, 1, 2, 3, 4, 5, 6, 9, 10, 11, 12, 13};
   localparam int FI_VAL [12] = '{372, 372, 558, 744, 1116, 1488, 1860, 512, 768, 1024, 1536,
      2048};
   localparam logic [3:0] DI_CODE [9] = '{1, 2, 3, 4, 5, 6, 8, 9, 7};
   localparam int DI_VAL [9] = '{1, 2, 4, 8, 16, 32, 12, 20, 0};
   localparam logic [31:0] MODE_LSB = 32'h0008_2300;
   localparam logic [31:0] MODE_MSB = 32'h000D_2300;
   always #2 sys_clk = ~sys_clk;
   utx_usart_tx dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rx_busy(rx_busy), .rx_on(rx_on), .rx_reset(rx_reset), .sck_in(1'b0),
      .sck_out(sck_out), .sck_oe(sck_oe), .txd(txd));
   utx_line_rx #(.BIT(8)) u_line (.sys_clk(sys_clk), .txd(txd), .rx_char(rx_char),
      .rx_count(rx_count), .frame_err(frame_err));
   always @(rx_count) if (rx_count > 0) got.push_back(rx_char);
   // ---------------------------------------------------------------
   // Bus cycles, comparison and closing.
   // ---------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic wait_st(input int b, input logic v);
      int n;
      n = 0;
      d = {32{~v}};
      while (d[b] !== v && n < 3000) begin
         rd(`UTX_OFS_STATUS, d);
         n++;
      end
      chk("status wait", {31'h0, n < 3000}, 32'h1);
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk);
      errors++;
      print_verdict;
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd(`UTX_OFS_ETU, d);
      chk("ratio reset", d, 32'h0010_0174);
      rd(`UTX_OFS_STATUS, d);
      chk("status reset", d, 32'h0);
      rd(`UTX_OFS_FACTOR, d);
      chk("factor reset", d, 32'h0001_0174);
      $display("reset test done");
      for (int i = 0; i < 12; i++) begin
         wr(`UTX_OFS_ETU, {8'h00, DI_CODE[i % 9], FI_CODE[i], 5'h00, 11'h174});
         rd(`UTX_OFS_FACTOR, d);
         chk("factors", d, {10'h0, 6'(DI_VAL[i % 9]), 4'h0, 12'(FI_VAL[i])});
      end
      wr(`UTX_OFS_ETU, 32'h0000_07FF);
      rd(`UTX_OFS_ETU, d);
      chk("ratio max", d & 32'h0000_07FF, 32'h0000_07FF);
      $display("table test done");
      wr(`UTX_OFS_MODE, MODE_LSB);
      wr(`UTX_OFS_BAUD, 32'h0000_0001);
      wr(`UTX_OFS_CONTROL, 32'h0000_0040);
      rd(`UTX_OFS_STATUS, d);
      chk("tx enabled", d, 32'h0000_0007);
      wr(`UTX_OFS_HOLD, 32'h0000_00B1);
      wait_st(0, 1'b1);
      wr(`UTX_OFS_HOLD, 32'h0000_003C);
      wr(`UTX_OFS_HOLD, 32'h0000_0055);
      wr(`UTX_OFS_CONTROL, 32'h0000_0080);
      wait_st(2, 1'b0);
      wr(`UTX_OFS_HOLD, 32'h0000_0066);
      repeat (200) @(posedge sys_clk);
      chk("char count", got.size(), 2);
      chk("first char", got[0], 32'h0000_00B1);
      chk("held char", got[1], 32'h0000_003C);
      $display("disable test done");
      wr(`UTX_OFS_CONTROL, 32'h0000_0040);
      wr(`UTX_OFS_MODE, MODE_MSB);
      wr(`UTX_OFS_HOLD, 32'h0000_00B1);
      wait_st(1, 1'b1);
      chk("msb char", got[2], 32'h0000_008D);
      chk("frame errors", frame_err, 32'h0);
      chk("drive out", sck_oe, 1'b1);
      $display("msb test done");
      @(posedge sys_clk);
      rx_busy <= 1'b1;
      wr(`UTX_OFS_CONTROL, 32'h0000_0010);
      wr(`UTX_OFS_CONTROL, 32'h0000_0024);
      repeat (4) @(posedge sys_clk);
      #1 chk("rx held on", rx_on, 1'b1);
      @(posedge sys_clk);
      rx_busy <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 chk("rx off", rx_on, 1'b0);
      $display("receiver test done");
      wr(`UTX_OFS_HOLD, 32'h0000_0000);
      repeat (30) @(posedge sys_clk);
      #1 chk("mid char", txd, 1'b0);
      wr(`UTX_OFS_CONTROL, 32'h0000_0008);
      repeat (2) @(posedge sys_clk);
      #1 chk("line idle", txd, 1'b1);
      rd(`UTX_OFS_STATUS, d);
      chk("status after reset", d, 32'h0000_0007);
      $display("soft reset test done");
      wr(`UTX_OFS_MODE, 32'h00A8_2300);
      wr(`UTX_OFS_HOLD, 32'h0000_00B1);
      @(negedge txd);
      repeat (2) @(posedge sys_clk);
      #1 chk("start first half", txd, 1'b0);
      repeat (4) @(posedge sys_clk);
      #1 chk("start second half", txd, 1'b1);
      repeat (8) @(posedge sys_clk);
      #1 chk("one second half", txd, 1'b0);
      $display("biphase test done");
      wr(`UTX_OFS_BAUD, 32'h0000_0004);
      @(posedge sck_out);
      @(posedge sys_clk);
      #1 chk("divided clock high", sck_out, 1'b1);
      repeat (2) @(posedge sys_clk);
      #1 chk("divided clock low", sck_out, 1'b0);
      $display("divided clock test done");
      print_verdict;
   end
endmodule // utx_usart_tx_tb
`default_nettype wire
